//--- rtl/fsc_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH
`define FSC_OFF_START     8'h00
`define FSC_OFF_SADDR     8'h04
`define FSC_OFF_MADDR     8'h08
`define FSC_OFF_STAT_LO   8'h0C
`define FSC_OFF_STAT_HI   8'h10
`define FSC_OFF_CLEAR     8'h14
`define FSC_LEN_W         24
`define FSC_DIR_BIT       31
`define FSC_HI_BUSY       10
`define FSC_HI_BLERR      11
`define FSC_HI_SDBE       12
`define FSC_HI_MDBE       13
`define FSC_HI_FATAL      14
`define FSC_HI_NDONE      15
`define FSC_HI_NDONE2     31
`define FSC_UNITS_PER_RDY 5'h10
`define FSC_UNIT_LAST     5'h1F
`define FSC_PTR_STEP      32'h0000_0002
`define FSC_RST_WORD      32'h0000_0000
`define FSC_CLK_MHZ       50
`define FSC_DONE_WAIT_NS  1000
`define FSC_DONE_WAIT_CYC ((`FSC_DONE_WAIT_NS * `FSC_CLK_MHZ) / 1000)
`endif

//--- rtl/fsc_ecc_check.sv
// Single-error-correct, double-error-detect check of one channel word.
`timescale 1ns/1ps
`default_nettype none
module fsc_ecc_check
   import fsc_pkg::*;
#(
   parameter int W = 72
) (
   // Word under test.
   input  wire logic [W-1:0] word_in,
   // Corrected word and error class.
   output logic      [W-1:0] word_fix,
   output logic              err_single,
   output logic              err_double
);
   localparam int SW = $clog2(W);

   logic [SW-1:0] syn;
   logic          par;

   function automatic logic [SW-1:0] syndrome(input logic [W-1:0] w);
      logic [SW-1:0] s;
      s = '0;
      for (int i = 1; i < W; i++) begin
         if (w[i]) begin
            s = s ^ SW'(i);
         end
      end
      return s;
   endfunction : syndrome

   // Odd parity with any syndrome is one bad bit; even parity with a
   // nonzero syndrome is two or more.
   always_comb begin
      syn        = syndrome(word_in);
      par        = ^word_in;
      word_fix   = word_in;
      err_single = par;
      err_double = !par && (syn != '0);
      if (par && (int'(syn) < W)) begin
         word_fix[syn] = ~word_in[syn];
      end
   end
endmodule : fsc_ecc_check
`default_nettype wire

//--- rtl/fsc_fast_storage_channel.sv
// Mainframe end of one fast storage channel with its APB registers.
// Functional notes
// - Each unit arrives as an even and an odd 72-bit word on two buses.
// - Every transfer starts by raising clear-channel toward the storage unit; a start with a reference pending goes straight to done without raising it.
// - After acknowledge, send start address and block length out.
// - Raise transmit-enable whenever an empty buffer can take data.
// - Enable, ready and data steps repeat until the final word.
// - Outbound: length reaching zero without last-word flag is an error.
// - Inbound: done-and-empty with nonzero remaining length is an error.
// - Inbound: done without done-and-empty following is an error.
// - Outbound: done-and-empty before last-word flag is an error.
// - Fatal error is the OR of all errors and an outstanding reference.
// - Mainframe corrects single-bit errors, stops on double-bit errors.
// - Memory read corrects single-byte errors, stops on multi-byte ones.
// - Send 32-bit address and length; storage blocks are half size.
// - Start word: length in bits 0-23, direction in bit 31.
// - Status gives remaining length and six flags at bits 42-47.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`include "fsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsc_fast_storage_channel
   import fsc_pkg::*;
#(
   parameter int DONE_WAIT = `FSC_DONE_WAIT_CYC
) (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Link control toward the storage unit.
   output logic             clear_chan,
   input  wire logic        clear_ack,
   output logic             param_valid,
   output logic      [31:0] param_addr,
   output logic      [31:0] param_len,
   output logic             param_dir,
   output logic             tx_enable,
   input  wire logic        data_ready,
   input  wire logic        done_empty,
   input  wire logic        storage_dbe,
   // Inbound unit from the storage unit.
   input  wire logic        unit_strobe,
   input  wire logic [71:0] even_word_lines,
   input  wire logic [71:0] odd_word_lines,
   // Outbound unit toward the storage unit.
   output logic      [71:0] wr_even,
   output logic      [71:0] wr_odd,
   output logic             wr_strobe,
   output logic             last_word_flag,
   // Memory side.
   output logic      [71:0] rx_even,
   output logic      [71:0] rx_odd,
   output logic             rx_valid,
   input  wire logic        buf_free,
   input  wire logic [71:0] tx_even,
   input  wire logic [71:0] tx_odd,
   input  wire logic        tx_valid,
   input  wire logic        tx_last,
   output logic             tx_ready,
   output logic      [31:0] mem_ptr,
   input  wire logic        mem_multi_byte_err,
   input  wire logic        ref_pending
);
   fsc_state_t           state;
   fsc_sync_t            sy0, sy1, sy2;
   fsc_sync_t            lvl;
   fsc_sync_t            lvl_q;
   fsc_sync_t            rise;
   logic [31:0]          storage_addr;
   logic [31:0]          memory_start_pointer;
   logic [`FSC_LEN_W-1:0] transfer_length;
   logic                 dir_out;
   logic [4:0]           unit_cnt;
   logic [4:0]           burst_left;
   logic [31:0]          wait_cnt;
   logic                 last_sent, done_flag, bl_err;
   logic                 sdbe_err, mdbe_err, fatal_err;
   logic [71:0]          fix_even;
   logic [71:0]          fix_odd;
   logic                 dbl_even, dbl_odd;
   logic                 wr_acc, start_wr, clear_wr, active;
   logic                 xfer, rx_take, tx_take, unit_ev;
   logic                 e_len, e_seq, e_sdbe, e_mdbe, e_ref, abort;

   // Pin inputs: three stages, a level changes once stages two and three agree.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sy0   <= '0;
         sy1   <= '0;
         sy2   <= '0;
         lvl   <= '0;
         lvl_q <= '0;
      end else begin
         sy0   <= {storage_dbe, done_empty, unit_strobe, data_ready, clear_ack};
         sy1   <= sy0;
         sy2   <= sy1;
         lvl   <= (~(sy1 ^ sy2) & sy2) | ((sy1 ^ sy2) & lvl);
         lvl_q <= lvl;
      end
   end
   assign rise = lvl & ~lvl_q;

   // Inbound words are checked and corrected one by one.
   fsc_ecc_check #(.W(72)) u_even (
      .word_in    (even_word_lines),
      .word_fix   (fix_even),
      .err_single (),
      .err_double (dbl_even)
   );
   fsc_ecc_check #(.W(72)) u_odd (
      .word_in    (odd_word_lines),
      .word_fix   (fix_odd),
      .err_single (),
      .err_double (dbl_odd)
   );

   // Transfer decode and error conditions.
   assign wr_acc   = psel && penable && pwrite;
   assign active   = !(state inside {FSC_IDLE, FSC_DONE});
   assign start_wr = wr_acc && (paddr == `FSC_OFF_START) && !active;
   assign clear_wr = wr_acc && (paddr == `FSC_OFF_CLEAR);
   assign xfer     = (state == FSC_XFER);
   assign rx_take  = xfer && !dir_out && rise[2] && (burst_left != 5'h00);
   assign tx_ready = xfer && dir_out && !last_sent
                     && (transfer_length != '0);
   assign tx_take  = tx_valid && tx_ready;
   assign unit_ev  = rx_take || tx_take;
   assign tx_enable = xfer && !dir_out && buf_free
                      && (burst_left == 5'h00);
   assign e_len    = xfer && dir_out && (transfer_length == '0)
                     && !last_sent;
   assign e_seq    = e_len
                     || ((xfer || state == FSC_DRAIN) && !dir_out && rise[3]
                         && (transfer_length != '0))
                     || (state == FSC_DRAIN && wait_cnt == 32'h0000_0000
                         && !lvl[3])
                     || (xfer && dir_out && rise[3] && !last_sent);
   assign e_sdbe   = active && rise[4];
   assign e_mdbe   = (rx_take && (dbl_even || dbl_odd))
                     || (tx_take && mem_multi_byte_err);
   assign e_ref    = start_wr && ref_pending;
   assign abort    = e_seq || e_sdbe || e_mdbe;

   // Sequence of one transfer.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= FSC_IDLE;
      end else begin
         case (state)
            FSC_IDLE, FSC_DONE: begin
               if (start_wr) begin
                  state <= e_ref ? FSC_DONE : FSC_CLEAR;
               end
            end
            FSC_CLEAR: begin
               if (abort) begin
                  state <= FSC_DONE;
               end else if (lvl[0]) begin
                  state <= FSC_PARAM;
               end
            end
            FSC_PARAM: begin
               state <= abort ? FSC_DONE : FSC_XFER;
            end
            FSC_XFER: begin
               if (abort) begin
                  state <= FSC_DONE;
               end else if (!dir_out && transfer_length == '0) begin
                  state <= FSC_DRAIN;
               end else if (dir_out && last_sent && rise[3]) begin
                  state <= FSC_DONE;
               end
            end
            FSC_DRAIN: begin
               if (abort || rise[3]) begin
                  state <= FSC_DONE;
               end
            end
            default: begin
               state <= FSC_IDLE;
            end
         endcase
      end
   end

   // Clear request and parameter strobe toward the storage unit.
   assign clear_chan  = (state == FSC_CLEAR);
   assign param_valid = (state == FSC_PARAM);

   // Software registers.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         storage_addr         <= `FSC_RST_WORD;
         memory_start_pointer <= `FSC_RST_WORD;
      end else if (wr_acc && !active) begin
         if (paddr == `FSC_OFF_SADDR) begin
            storage_addr <= pwdata;
         end
         if (paddr == `FSC_OFF_MADDR) begin
            memory_start_pointer <= pwdata;
         end
      end
   end

   // Parameters latched at start; storage blocks are half as long.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         param_addr <= `FSC_RST_WORD;
         param_len  <= `FSC_RST_WORD;
         param_dir  <= 1'b0;
         dir_out    <= 1'b0;
      end else if (start_wr) begin
         param_addr <= storage_addr;
         param_len  <= {7'h00, pwdata[`FSC_LEN_W-1:0], 1'b0};
         param_dir  <= pwdata[`FSC_DIR_BIT];
         dir_out    <= pwdata[`FSC_DIR_BIT];
      end
   end

   // Remaining length counts down one block per 32 units of two words.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         transfer_length <= '0;
         unit_cnt        <= 5'h00;
         mem_ptr         <= `FSC_RST_WORD;
      end else if (start_wr) begin
         transfer_length <= pwdata[`FSC_LEN_W-1:0];
         unit_cnt        <= 5'h00;
         mem_ptr         <= memory_start_pointer;
      end else if (unit_ev) begin
         unit_cnt <= unit_cnt + 5'h01;
         mem_ptr  <= mem_ptr + `FSC_PTR_STEP;
         if (unit_cnt == `FSC_UNIT_LAST) begin
            transfer_length <= transfer_length - `FSC_LEN_W'(1);
         end
      end
   end

   // Each data-ready opens a window of sixteen inbound units.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         burst_left <= 5'h00;
      end else if (!xfer) begin
         burst_left <= 5'h00;
      end else if (rise[1] && burst_left == 5'h00) begin
         burst_left <= `FSC_UNITS_PER_RDY;
      end else if (rx_take) begin
         burst_left <= burst_left - 5'h01;
      end
   end

   // Inbound data to memory, corrected.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_even  <= '0;
         rx_odd   <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= rx_take;
         if (rx_take) begin
            rx_even <= fix_even;
            rx_odd  <= fix_odd;
         end
      end
   end

   // Outbound data and last-word flag to the storage unit.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_even        <= '0;
         wr_odd         <= '0;
         wr_strobe      <= 1'b0;
         last_sent      <= 1'b0;
      end else begin
         wr_strobe <= tx_take;
         if (start_wr) begin
            last_sent <= 1'b0;
         end else if (tx_take) begin
            wr_even   <= tx_even;
            wr_odd    <= tx_odd;
            last_sent <= tx_last;
         end
      end
   end
   assign last_word_flag = last_sent;

   // Wait for done-and-empty after the inbound length runs out.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wait_cnt <= 32'h0000_0000;
      end else if (state != FSC_DRAIN) begin
         wait_cnt <= 32'(DONE_WAIT);
      end else if (wait_cnt != 32'h0000_0000) begin
         wait_cnt <= wait_cnt - 32'h0000_0001;
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done_flag <= 1'b0;
         bl_err    <= 1'b0;
         sdbe_err  <= 1'b0;
         mdbe_err  <= 1'b0;
         fatal_err <= 1'b0;
      end else begin
         done_flag <= (done_flag && !clear_wr && !start_wr)
                      || (active && state != FSC_IDLE
                          && (abort || (state == FSC_DRAIN && rise[3])
                              || (xfer && dir_out && last_sent
                                  && rise[3])))
                      || e_ref;
         bl_err    <= (bl_err && !clear_wr && !start_wr) || e_seq;
         sdbe_err  <= (sdbe_err && !clear_wr && !start_wr) || e_sdbe;
         mdbe_err  <= (mdbe_err && !clear_wr && !start_wr) || e_mdbe;
         fatal_err <= (fatal_err && !clear_wr && !start_wr)
                      || abort || e_ref;
      end
   end

   // APB read data and error are taken in the setup cycle.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata  <= `FSC_RST_WORD;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= `FSC_RST_WORD;
         pslverr <= 1'b0;
         case (paddr)
            `FSC_OFF_START: prdata <= {dir_out, 7'h00, transfer_length};
            `FSC_OFF_SADDR: prdata <= storage_addr;
            `FSC_OFF_MADDR: prdata <= memory_start_pointer;
            `FSC_OFF_STAT_LO: begin
               prdata[`FSC_LEN_W-1:0] <= transfer_length;
            end
            `FSC_OFF_STAT_HI: begin
               prdata[`FSC_HI_BUSY]   <= active;
               prdata[`FSC_HI_BLERR]  <= bl_err;
               prdata[`FSC_HI_SDBE]   <= sdbe_err;
               prdata[`FSC_HI_MDBE]   <= mdbe_err;
               prdata[`FSC_HI_FATAL]  <= fatal_err;
               prdata[`FSC_HI_NDONE]  <= !done_flag;
               prdata[`FSC_HI_NDONE2] <= !done_flag;
            end
            `FSC_OFF_CLEAR: prdata <= `FSC_RST_WORD;
            default: pslverr <= 1'b1;
         endcase
      end
   end
   assign pready = 1'b1;
endmodule : fsc_fast_storage_channel
`default_nettype wire

//--- rtl/fsc_pkg.sv
// Types shared by the fast storage channel design.
package fsc_pkg;
   typedef enum logic [5:0] {
      FSC_IDLE  = 6'b000001,
      FSC_CLEAR = 6'b000010,
      FSC_PARAM = 6'b000100,
      FSC_XFER  = 6'b001000,
      FSC_DRAIN = 6'b010000,
      FSC_DONE  = 6'b100000
   } fsc_state_t;
   typedef logic [4:0] fsc_sync_t;
endpackage : fsc_pkg

//--- testbench/fsc_channel_asserts.sv
// Port assertions for the fast storage channel.
`timescale 1ns/1ps
`default_nettype none
module fsc_channel_asserts #(
   parameter int DONE_WAIT = 50
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Watched ports.
   input wire logic pready,
   input wire logic clear_chan,
   input wire logic clear_ack,
   input wire logic param_valid,
   input wire logic param_dir,
   input wire logic tx_enable,
   input wire logic buf_free,
   input wire logic rx_valid,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic wr_strobe,
   input wire logic last_word_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_zero_wait: assert property (pready)
      else $error("pready low");
   a_clear_first: assert property (param_valid |-> $past(clear_chan))
      else $error("param without clear");
   a_clear_holds: assert property (
      $rose(clear_ack) && clear_chan |=> clear_chan [*2])
      else $error("clear dropped early");
   a_param_ack: assert property (param_valid |-> $past(clear_ack, 3))
      else $error("param before ack");
   a_param_pulse: assert property (param_valid |=> !param_valid)
      else $error("param not a pulse");
   a_txen_cause: assert property (
      tx_enable |-> !param_dir && buf_free && !clear_chan)
      else $error("tx_enable out of place");
   a_rx_pulse: assert property (rx_valid |=> !rx_valid)
      else $error("rx_valid not a pulse");
   a_txrdy_cause: assert property (
      tx_ready |-> param_dir && !last_word_flag && !tx_enable)
      else $error("tx_ready out of place");
   a_strobe_cause: assert property (
      wr_strobe |-> $past(tx_valid && tx_ready))
      else $error("strobe without unit");
   a_last_unit: assert property ($rose(last_word_flag) |-> wr_strobe)
      else $error("last flag without unit");
endmodule : fsc_channel_asserts
`default_nettype wire

//--- testbench/fsc_storage_model.sv
// Behavioural storage unit at the far end of the channel.
`timescale 1ns/1ps
`default_nettype none
module fsc_storage_model (
   // Control from the mainframe.
   input  wire logic        sys_clk,
   input  wire logic        clear_chan,
   input  wire logic        param_dir,
   input  wire logic        tx_enable,
   input  wire logic        last_word_flag,
   // Fault choice: 0 clean, 1 early done, 2 no done (inbound; early done outbound), 3 double-bit error (outbound; clean inbound).
   input  wire logic [1:0]  mode,
   // Answers toward the mainframe.
   output logic             clear_ack,
   output logic             data_ready,
   output logic             done_empty,
   output logic             storage_dbe,
   output logic             unit_strobe,
   output logic      [71:0] even_word_lines,
   output logic      [71:0] odd_word_lines
);
   int w;
   int u;
   initial begin
      clear_ack = 1'b0;
      data_ready = 1'b0;
      done_empty = 1'b0;
      storage_dbe = 1'b0;
      unit_strobe = 1'b0;
      even_word_lines = 72'h0;
      odd_word_lines = 72'h0;
   end
   task step(input int c);
      repeat (c) @(posedge sys_clk);
   endtask : step
   task pulse_done;
      step(1);
      done_empty <= 1'b1;
      step(4);
      done_empty <= 1'b0;
   endtask : pulse_done
   task send_unit(input logic [71:0] ev);
      even_word_lines <= ev;
      odd_word_lines <= 72'h0;
      step(4);
      unit_strobe <= 1'b1;
      step(4);
      unit_strobe <= 1'b0;
      step(4);
      even_word_lines <= ~ev;
      odd_word_lines <= ~72'h0;
      step(2);
   endtask : send_unit
   always begin
      @(posedge clear_chan);
      step(5);
      clear_ack <= 1'b1;
      wait (!clear_chan);
      step(1);
      clear_ack <= 1'b0;
      step(4);
      if (param_dir && mode == 2'h3) begin
         step(1);
         storage_dbe <= 1'b1;
         step(4);
         storage_dbe <= 1'b0;
      end else if (param_dir) begin
         if (mode == 2'h0) wait (last_word_flag);
         pulse_done;
      end else begin
         for (w = 0; w < 2 && !(mode == 2'h1 && w == 1); w++) begin
            wait (tx_enable);
            step(1);
            data_ready <= 1'b1;
            step(4);
            data_ready <= 1'b0;
            for (u = 0; u < 16; u++) begin
               send_unit((w + u == 0) ? 72'hF ^ 72'h10_0000 : 72'hF);
            end
         end
         if (mode != 2'h2) pulse_done;
      end
   end
endmodule : fsc_storage_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the fast storage channel.
`include "fsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, param_addr, param_len, mem_ptr, p_len;
   logic [31:0] p_addr;
   logic clear_chan, clear_ack, param_valid, param_dir, tx_enable;
   logic data_ready, done_empty, storage_dbe, unit_strobe, wr_strobe;
   logic last_word_flag, rx_valid, buf_free, tx_valid, tx_last, tx_ready;
   logic ref_pending, mem_mbe;
   logic [71:0] even_word_lines, odd_word_lines, wr_even, wr_odd;
   logic [71:0] rx_even, rx_odd, tx_even, tx_odd, rx_first;
   logic [1:0] mode;
   int n_errors = 0, compares = 0, n_rx, n_wr;
   fsc_fast_storage_channel #(.DONE_WAIT(20)) fsc_fast_storage_channel_i (
      .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .clear_chan, .clear_ack, .param_valid, .param_addr,
      .param_len, .param_dir, .tx_enable, .data_ready, .done_empty,
      .storage_dbe, .unit_strobe, .even_word_lines, .odd_word_lines,
      .wr_even, .wr_odd, .wr_strobe, .last_word_flag, .rx_even, .rx_odd,
      .rx_valid, .buf_free, .tx_even, .tx_odd, .tx_valid, .tx_last,
      .tx_ready, .mem_ptr, .mem_multi_byte_err(mem_mbe), .ref_pending);
   fsc_storage_model fsc_storage_model_i (
      .sys_clk, .clear_chan, .param_dir, .tx_enable, .last_word_flag,
      .mode, .clear_ack, .data_ready, .done_empty, .storage_dbe,
      .unit_strobe, .even_word_lines, .odd_word_lines);
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1) begin
         if (n_rx == 0) rx_first <= rx_even;
         n_rx <= n_rx + 1;
      end
      if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
      if (param_valid === 1'b1) begin
         p_len <= param_len;
         p_addr <= param_addr;
      end
   end
   task test_done;
      $display("Compares %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [71:0] e, input logic [71:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         test_done;
      end
   endtask : apb
   task run(input logic [31:0] cmd, input logic [1:0] md);
      int n;
      mode <= md;
      n_rx = 0;
      n_wr = 0;
      apb(1'b1, `FSC_OFF_SADDR, 32'h0000_1230);
      apb(1'b1, `FSC_OFF_MADDR, 32'h0000_0400);
      apb(1'b1, `FSC_OFF_START, cmd);
      n = 0;
      do begin
         apb(1'b0, `FSC_OFF_STAT_HI, 32'h0);
         n++;
      end while (rd[15] !== 1'b0 && n < 400);
      if (n >= 400) begin
         n_errors++;
         test_done;
      end
   endtask : run
   task send(input int units);
      int k;
      int n;
      tx_valid <= 1'b1;
      k = 0;
      n = 0;
      while (k < units && n < 2000) begin
         @(posedge sys_clk);
         n++;
         if (tx_ready === 1'b1) begin
            k++;
            tx_last <= (k == units - 1);
         end
      end
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      if (k < units) begin
         n_errors++;
         test_done;
      end
   endtask : send
   task t_reset;
      apb(1'b0, `FSC_OFF_STAT_HI, 32'h0);
      chk("stat_hi", 32'h8000_8000, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("slverr", 1'b1, err);
   endtask : t_reset
   task t_in_ok;
      run(32'h0000_0001, 2'h0);
      chk("param_len", 32'h0000_0002, p_len);
      chk("param_addr", 32'h0000_1230, p_addr);
      chk("units", 32, n_rx);
      chk("rx_fix", 72'hF, rx_first);
      chk("stat_hi", 32'h0, rd);
      chk("mem_ptr", 32'h0000_0440, mem_ptr);
      apb(1'b0, `FSC_OFF_STAT_LO, 32'h0);
      chk("remain", 32'h0, rd);
   endtask : t_in_ok
   task t_in_faults;
      run(32'h0000_0001, 2'h1);
      chk("stat_hi", 32'h0000_4800, rd);
      run(32'h0000_0001, 2'h2);
      chk("fatal", 1'b1, rd[14]);
   endtask : t_in_faults
   task t_out_ok;
      fork
         run(32'h8000_0001, 2'h0);
         send(32);
      join
      chk("units", 32, n_wr);
      chk("last", 1'b1, last_word_flag);
      chk("wr_even", 72'hF, wr_even);
      chk("stat_hi", 32'h0, rd);
   endtask : t_out_ok
   task t_out_faults;
      run(32'h8000_0001, 2'h1);
      chk("stat_hi", 32'h0000_4800, rd);
      run(32'h8000_0000, 2'h1);
      chk("stat_hi", 32'h0000_4800, rd);
   endtask : t_out_faults
   task t_ref;
      ref_pending <= 1'b1;
      run(32'h0000_0001, 2'h1);
      chk("fatal", 1'b1, rd[14]);
      ref_pending <= 1'b0;
   endtask : t_ref
   task t_far_errs;
      run(32'h8000_0001, 2'h3);
      chk("stat_hi", 32'h0000_5000, rd);
      mem_mbe <= 1'b1;
      fork
         run(32'h8000_0001, 2'h1);
         send(1);
      join
      chk("stat_hi", 32'h0000_6000, rd);
      mem_mbe <= 1'b0;
   endtask : t_far_errs
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, tx_valid, tx_last, ref_pending, mem_mbe} = 7'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      buf_free = 1'b1;
      tx_even = 72'hF;
      tx_odd = 72'h0;
      mode = 2'h0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_in_ok;
      t_in_faults;
      t_out_ok;
      t_out_faults;
      t_ref;
      t_far_errs;
      test_done;
   end
endmodule : tb
bind fsc_fast_storage_channel fsc_channel_asserts #(
   .DONE_WAIT(DONE_WAIT)
) fsc_channel_asserts_i (
   .sys_clk, .rst, .pready, .clear_chan, .clear_ack, .param_valid,
   .param_dir, .tx_enable, .buf_free, .rx_valid, .tx_valid, .tx_ready,
   .wr_strobe, .last_word_flag);
`default_nettype wire
